// file: src/ldp_top.sv
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// Overview of operation
// - four indicator sinks, six current steps each
// - brightness via current step or pulse gating
// - software-written settings apply as last written
// - every driver keeps independent dimming settings
// - period is 32 slots, duty+1 high
// - duty code five bits, 0 to 31
// - each driver has its own divider
// - sink slot is div+1 microseconds, div<=312499
// - flash and keypad divider limited to 255
module ldp_top (
	input  wire logic                       clock_i,                  // 40 MHz system clock
	input  wire logic                       nrst_i,                   // synchronous reset, active low
	input  wire logic [ldp_pkg::ADDR_W-1:0] avs_address_i,            // byte address
	input  wire logic                       avs_read_i,               // read request
	input  wire logic                       avs_write_i,              // write request
	input  wire logic [31:0]                avs_writedata_i,          // write data
	input  wire logic [3:0]                 avs_byteenable_i,         // write byte lanes
	output logic      [31:0]                avs_readdata_o,           // read data
	output logic                            avs_waitrequest_o,        // stall
	output logic      [ldp_pkg::NSINK-1:0]  indicator_current_sink_o, // sink gates
	output logic      [ldp_pkg::NSINK*ldp_pkg::STEP_W-1:0] indicator_step_o, // sink current steps
	output logic                            keypad_led_driver_o,      // keypad gate
	output logic                            flash_driver_o,           // flash gate
	output logic                            backlight_driver_o,       // backlight gate
	output logic                            haptic_motor_driver_o     // haptic gate
);
	import ldp_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ldp_bus_t                bus_q, bus_d;
	logic [31:0]             rdata_q, rdata_d;
	logic [NCH-1:0]          en_q, en_d;
	logic [DUTY_W-1:0]       duty_q [NCH];
	logic [DUTY_W-1:0]       duty_d [NCH];
	logic [STEP_W-1:0]       step_q [NSINK];
	logic [STEP_W-1:0]       step_d [NSINK];
	logic [SINK_DIV_W-1:0]   div_q  [NCH];
	logic [SINK_DIV_W-1:0]   div_d  [NCH];
	logic [TB_W-1:0]         tb_q, tb_d;
	logic                    tick_q, tick_d;
	logic [NCH-1:0]          pwm;

	// ----------------------------------------------------------------
	// 1 MHz timebase
	// ----------------------------------------------------------------
	// one tick strobe shared by all channels keeps them in the same scheme
	always_comb begin
		tick_d = (tb_q == TB_LAST);
		tb_d   = tick_d ? '0 : tb_q + 1'b1;
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			tb_q   <= '0;
			tick_q <= 1'b0;
		end else begin
			tb_q   <= tb_d;
			tick_q <= tick_d;
		end
	end

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic                     hit_ctrl, hit_div, hit_status;
	logic [2:0]               sel;
	logic [31:0]              wmask;
	logic [31:0]              ctrl_word [NCH];
	logic [31:0]              div_word  [NCH];

	assign sel        = avs_address_i[CH_STRIDE_SH +: 3];
	assign hit_ctrl   = (avs_address_i < OFS_STATUS) &&
	                    (avs_address_i[CH_STRIDE_SH-1:0] == OFS_CTRL0[CH_STRIDE_SH-1:0]);
	assign hit_div    = (avs_address_i < OFS_STATUS) &&
	                    (avs_address_i[CH_STRIDE_SH-1:0] == OFS_DIV0[CH_STRIDE_SH-1:0]);
	assign hit_status = (avs_address_i == OFS_STATUS);

	// byte enables expanded to a bit mask for read-modify-write
	assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
	                {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

	// ----------------------------------------------------------------
	// register words as software sees them
	// ----------------------------------------------------------------
	// step field reads zero on channels without a current sink
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			ctrl_word[i] = CTRL_RESET;
			ctrl_word[i][CTRL_EN_BIT] = en_q[i];
			ctrl_word[i][CTRL_DUTY_LSB +: DUTY_W] = duty_q[i];
			if (i < NSINK) begin
				ctrl_word[i][CTRL_STEP_LSB +: STEP_W] = step_q[i];
			end
			div_word[i] = DIV_RESET;
			div_word[i][SINK_DIV_W-1:0] = div_q[i];
		end
	end

	// ----------------------------------------------------------------
	// bus handshake and register writes
	// ----------------------------------------------------------------
	// one wait cycle: request seen in idle, answered in ack
	logic [31:0] merged;
	logic [STEP_W-1:0]     new_step;
	logic [SINK_DIV_W-1:0] new_div;

	always_comb begin
		bus_d   = bus_q;
		rdata_d = rdata_q;
		en_d    = en_q;
		merged  = '0;
		new_step = '0;
		new_div  = '0;
		for (int i = 0; i < NCH; i++) begin
			duty_d[i] = duty_q[i];
			div_d[i]  = div_q[i];
		end
		for (int i = 0; i < NSINK; i++) begin
			step_d[i] = step_q[i];
		end
		unique case (bus_q)
			LDP_BUS_IDLE: begin
				if (avs_read_i || avs_write_i) begin
					bus_d = LDP_BUS_ACK;
					// unmapped reads answer zero
					if (hit_ctrl) begin
						rdata_d = ctrl_word[sel];
					end else if (hit_div) begin
						rdata_d = div_word[sel];
					end else if (hit_status) begin
						rdata_d = {{(32-NCH){1'b0}}, pwm};
					end else begin
						rdata_d = '0;
					end
				end
			end
			LDP_BUS_ACK: begin
				bus_d = LDP_BUS_IDLE;
				if (avs_write_i && hit_ctrl) begin
					merged = (ctrl_word[sel] & ~wmask) | (avs_writedata_i & wmask);
					en_d[sel]   = merged[CTRL_EN_BIT];
					duty_d[sel] = merged[CTRL_DUTY_LSB +: DUTY_W];
					new_step = merged[CTRL_STEP_LSB +: STEP_W];
					if (new_step > STEP_MAX) begin
						new_step = STEP_MAX;
					end
					if (sel < 3'(NSINK)) begin
						step_d[sel[1:0]] = new_step;
					end
				end else if (avs_write_i && hit_div) begin
					merged  = (div_word[sel] & ~wmask) | (avs_writedata_i & wmask);
					new_div = merged[SINK_DIV_W-1:0];
					// codes beyond the range saturate rather than wrap
					if (sel < 3'(NSINK)) begin
						if (new_div > SINK_DIV_MAX) begin
							new_div = SINK_DIV_MAX;
						end
					end else if (new_div > AUX_DIV_MAX) begin
						new_div = AUX_DIV_MAX;
					end
					div_d[sel] = new_div;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			bus_q   <= LDP_BUS_IDLE;
			rdata_q <= '0;
			en_q    <= '0;
			for (int i = 0; i < NCH; i++) begin
				duty_q[i] <= '0;
				div_q[i]  <= '0;
			end
			for (int i = 0; i < NSINK; i++) begin
				step_q[i] <= '0;
			end
		end else begin
			bus_q   <= bus_d;
			rdata_q <= rdata_d;
			en_q    <= en_d;
			for (int i = 0; i < NCH; i++) begin
				duty_q[i] <= duty_d[i];
				div_q[i]  <= div_d[i];
			end
			for (int i = 0; i < NSINK; i++) begin
				step_q[i] <= step_d[i];
			end
		end
	end

	// handshake outputs are combinational; read data comes from a flop
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (bus_q != LDP_BUS_ACK);
	assign avs_readdata_o    = rdata_q;

	// ----------------------------------------------------------------
	// channel generators
	// ----------------------------------------------------------------
	// sinks get the wide divider, the others the narrow one
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		localparam int DW = (g < NSINK) ? SINK_DIV_W : AUX_DIV_W;
		ldp_chan_if #(.DIV_W(DW)) cif ();

		assign cif.tick = tick_q;
		assign cif.en   = en_q[g];
		assign cif.duty = duty_q[g];
		assign cif.div  = div_q[g][DW-1:0];
		assign pwm[g]   = cif.pwm;

		ldp_chan u_chan (
			.clock_i (clock_i),
			.nrst_i  (nrst_i),
			.cfg     (cif)
		);
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// step drives the sink level, pwm gates it: both dimming methods
	for (genvar s = 0; s < NSINK; s++) begin : g_step
		assign indicator_step_o[s*STEP_W +: STEP_W] = step_q[s];
	end

	assign indicator_current_sink_o = pwm[NSINK-1:0];
	assign keypad_led_driver_o      = pwm[CH_KEYPAD];
	assign flash_driver_o           = pwm[CH_FLASH];
	assign backlight_driver_o       = pwm[CH_BACKLT];
	assign haptic_motor_driver_o    = pwm[CH_HAPTIC];
endmodule

// file: src/ldp_pkg.sv
package ldp_pkg;
	// ----------------------------------------------------------------
	// channel layout
	// ----------------------------------------------------------------
	localparam int NCH        = 8;  // 4 sinks, keypad, flash, backlight, haptic
	localparam int NSINK      = 4;  // channels 0..3 are indicator sinks
	localparam int CH_KEYPAD  = 4;
	localparam int CH_FLASH   = 5;
	localparam int CH_BACKLT  = 6;
	localparam int CH_HAPTIC  = 7;
	localparam int DUTY_W     = 5;
	localparam int STEP_W     = 3;
	localparam int SINK_DIV_W = 19;
	localparam int AUX_DIV_W  = 8;
	localparam logic [SINK_DIV_W-1:0] SINK_DIV_MAX = 19'd312499;
	localparam logic [SINK_DIV_W-1:0] AUX_DIV_MAX  = 19'd255;
	localparam logic [STEP_W-1:0]     STEP_MAX     = 3'd5;     // six steps, 0..5

	// ----------------------------------------------------------------
	// timebase
	// ----------------------------------------------------------------
	localparam int CLK_HZ    = 40_000_000;
	localparam int TB_HZ     = 1_000_000;
	localparam int TB_CYCLES = CLK_HZ / TB_HZ;             // 40 clocks per timebase tick
	localparam int TB_W      = 6;
	localparam logic [TB_W-1:0] TB_LAST = TB_W'(TB_CYCLES - 1);

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam logic [ADDR_W-1:0] OFS_CTRL0  = 7'h00;      // channel n control at OFS_CTRL0 + 8n
	localparam logic [ADDR_W-1:0] OFS_DIV0   = 7'h04;      // channel n divider at OFS_DIV0 + 8n
	localparam logic [ADDR_W-1:0] OFS_STATUS = 7'h40;      // live output levels
	localparam int CH_STRIDE_SH = 3;
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_DUTY_LSB = 8;
	localparam int CTRL_STEP_LSB = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] DIV_RESET  = 32'h0000_0000;

	// ----------------------------------------------------------------
	// bus handshake states
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		LDP_BUS_IDLE = 1'b0,
		LDP_BUS_ACK  = 1'b1
	} ldp_bus_t;
endpackage

// file: src/ldp_chan_if.sv
`timescale 1ns/1ps
// settings and output of one dimming channel
interface ldp_chan_if #(
	parameter int DIV_W = 8
);
	logic                     tick;   // 1 MHz timebase strobe
	logic                     en;     // channel enable
	logic [ldp_pkg::DUTY_W-1:0] duty; // duty code
	logic [DIV_W-1:0]         div;    // divider code
	logic                     pwm;    // dimming output

	modport ctrl (output tick, output en, output duty, output div, input pwm);
	modport chan (input tick, input en, input duty, input div, output pwm);
endinterface

// file: src/ldp_chan.sv
`timescale 1ns/1ps
// one dimming pulse generator: prescaler plus 32-slot counter
module ldp_chan (
	input  wire logic clock_i, // system clock
	input  wire logic nrst_i,  // synchronous reset, active low
	ldp_chan_if.chan  cfg      // settings in, pwm out
);
	import ldp_pkg::*;

	localparam int DW = $bits(cfg.div);

	logic [DW-1:0]     pre_q, pre_d;
	logic [DUTY_W-1:0] slot_q, slot_d;
	logic              pwm_q, pwm_d;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// slot lasts div+1 ticks; five-bit slot wraps after 32 slots
	always_comb begin
		pre_d  = pre_q;
		slot_d = slot_q;
		if (!cfg.en) begin
			pre_d  = '0;
			slot_d = '0;
		end else if (cfg.tick) begin
			if (pre_q >= cfg.div) begin
				pre_d  = '0;
				slot_d = slot_q + 1'b1;
			end else begin
				pre_d = pre_q + 1'b1;
			end
		end
		// high for duty+1 slots, low for the rest; live duty so a rewrite takes effect at once
		pwm_d = cfg.en && (slot_q <= cfg.duty);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			pre_q  <= '0;
			slot_q <= '0;
			pwm_q  <= 1'b0;
		end else begin
			pre_q  <= pre_d;
			slot_q <= slot_d;
			pwm_q  <= pwm_d;
		end
	end

	assign cfg.pwm = pwm_q;
endmodule

// file: verification/ldp_led_model.sv
`timescale 1ns/1ps
// led load on one gate: times the last on-run and the last rise-to-rise span
module ldp_led_model (
	input  wire logic clock_i, // system clock
	input  wire logic gate_i,  // sink gate
	output int        hi_o,    // clocks of last on-run
	output int        per_o    // clocks of last period
);
	int   run;
	int   span;
	logic prev;
	// a load has no memory of its own, so only whole runs are reported
	always @(posedge clock_i) begin
		prev <= gate_i;
		run <= gate_i ? run + 1 : 0;
		span <= (gate_i && !prev) ? 1 : span + 1;
		if (!gate_i && prev) hi_o <= run;
		if (gate_i && !prev) per_o <= span;
	end
endmodule

// file: verification/ldp_top_monitor.sv
`timescale 1ns/1ps
// watches the bus and gate pins of the dimming block
module ldp_top_monitor (
	input wire logic                                    clock_i,                  // clock
	input wire logic                                    nrst_i,                   // reset, active low
	input wire logic [ldp_pkg::ADDR_W-1:0]              avs_address_i,            // address
	input wire logic                                    avs_read_i,               // read
	input wire logic                                    avs_write_i,              // write
	input wire logic [31:0]                             avs_writedata_i,          // write data
	input wire logic [3:0]                              avs_byteenable_i,         // lanes
	input wire logic [31:0]                             avs_readdata_o,           // read data
	input wire logic                                    avs_waitrequest_o,        // stall
	input wire logic [ldp_pkg::NSINK-1:0]               indicator_current_sink_o, // sink gates
	input wire logic [ldp_pkg::NSINK*ldp_pkg::STEP_W-1:0] indicator_step_o,       // steps
	input wire logic                                    keypad_led_driver_o,      // keypad
	input wire logic                                    flash_driver_o,           // flash
	input wire logic                                    backlight_driver_o,       // backlight
	input wire logic                                    haptic_motor_driver_o     // haptic
);
	import ldp_pkg::*;
	// ---------
	// helpers
	// ---------
	wire logic       req = avs_read_i || avs_write_i;
	wire logic       rack = avs_read_i && !avs_waitrequest_o;
	wire logic [6:0] a = avs_address_i;
	wire logic [31:0] r = avs_readdata_o;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	property p_wait_one;
		req && !$past(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait state not one cycle");
	property p_idle; !req |-> !avs_waitrequest_o; endproperty
	a_idle: assert property (p_idle) else $error("stall with no request");
	property p_reset_off;
		$rose(nrst_i) |-> indicator_current_sink_o == 0 && !keypad_led_driver_o && !flash_driver_o
			&& !backlight_driver_o && !haptic_motor_driver_o && indicator_step_o == 0;
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("driver on after reset");
	property p_step_range;
		indicator_step_o[2:0] <= 3'h5 && indicator_step_o[5:3] <= 3'h5
			&& indicator_step_o[8:6] <= 3'h5 && indicator_step_o[11:9] <= 3'h5;
	endproperty
	a_step_range: assert property (p_step_range) else $error("current step beyond six");
	property p_unmapped; rack && a > 7'h40 |-> r == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_ctrl_read;
		rack && a < 7'h40 && a[2:0] == 3'h0 |-> r[31:19] == 0 && r[15:13] == 0 && r[7:1] == 0
			&& r[18:16] <= 3'h5 && (!a[5] || r[18:16] == 0);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control readback field bad");
	property p_div_read;
		rack && a < 7'h40 && a[2:0] == 3'h4 |-> r[31:19] == 0 && (a[5] ? r[18:8] == 0 : r[18:0] <= SINK_DIV_MAX);
	endproperty
	a_div_read: assert property (p_div_read) else $error("divider beyond range");
	property p_status_read; rack && a == OFS_STATUS |-> r[31:8] == 0; endproperty
	a_status_read: assert property (p_status_read) else $error("status upper bits set");
endmodule
bind ldp_top ldp_top_monitor ldp_top_monitor_inst (.clock_i(clock_i), .nrst_i(nrst_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .indicator_current_sink_o(indicator_current_sink_o),
	.indicator_step_o(indicator_step_o), .keypad_led_driver_o(keypad_led_driver_o),
	.flash_driver_o(flash_driver_o), .backlight_driver_o(backlight_driver_o),
	.haptic_motor_driver_o(haptic_motor_driver_o));

// file: verification/ldp_top_test.sv
`timescale 1ns/1ps
module ldp_top_test;
	import ldp_pkg::*;
	logic                    clock_i = 1'b0;
	logic                    nrst_i = 1'b0;
	logic                    rd = 1'b0;
	logic                    wr = 1'b0;
	logic [ADDR_W-1:0]       addr = '0;
	logic [31:0]             wdata = '0;
	logic [3:0]              be = 4'hF;
	logic [31:0]             rdata;
	logic [31:0]             q;
	logic                    wait_o;
	logic [NSINK*STEP_W-1:0] steps;
	logic [NCH-1:0]          gates;
	int                      hi[NCH];
	int                      per[NCH];
	int                      mismatches = 0;
	int                      checks = 0;
	// ---------
	// block and loads
	// ---------
	ldp_top ldp_top_inst (.clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_o), .indicator_current_sink_o(gates[3:0]), .indicator_step_o(steps),
		.keypad_led_driver_o(gates[4]), .flash_driver_o(gates[5]), .backlight_driver_o(gates[6]),
		.haptic_motor_driver_o(gates[7]));
	for (genvar g = 0; g < NCH; g++) begin : g_led
		ldp_led_model ldp_led_model_inst (.clock_i(clock_i), .gate_i(gates[g]), .hi_o(hi[g]), .per_o(per[g]));
	end
	always #12.5 clock_i = ~clock_i;
	// ---------
	// bus and compare tasks
	// ---------
	// one edge passes before each request so no signal is assigned twice in a step
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge clock_i);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		be <= b;
		do @(posedge clock_i); while (wait_o !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0, 4'hF);
		chk(q, exp);
	endtask
	task automatic report_and_stop;
		if (mismatches == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// watchdog sized to over twice the longest wait below
	initial begin
		repeat (70000) @(posedge clock_i);
		mismatches++;
		report_and_stop();
	end
	// ---------
	// main sequence
	// ---------
	initial begin
		repeat (16) @(posedge clock_i);
		nrst_i <= 1'b1;
		rdchk(OFS_CTRL0, CTRL_RESET);
		rdchk(OFS_DIV0, DIV_RESET);
		rdchk(OFS_STATUS, 32'h0);
		xfer(1'b1, OFS_DIV0, 32'hFFFF_FFFF, 4'hF);
		rdchk(OFS_DIV0, {13'h0, SINK_DIV_MAX});
		xfer(1'b1, 7'h24, 32'h0000_012C, 4'hF);
		rdchk(7'h24, 32'h0000_00FF);
		xfer(1'b1, 7'h0C, 32'hFFFF_FFFF, 4'h1);
		rdchk(7'h0C, 32'h0000_00FF);
		xfer(1'b1, 7'h44, 32'hFFFF_FFFF, 4'hF);
		rdchk(7'h44, 32'h0);
		// every channel gets its own duty and divider, each sink its own step
		for (int n = 0; n < NCH; n++) begin
			xfer(1'b1, 7'(n * 8), 32'(1 | (n * 4) << 8 | (7 - n) << 16), 4'hF);
			xfer(1'b1, 7'(n * 8 + 4), 32'(n), 4'hF);
		end
		for (int n = 0; n < NCH; n++) begin
			rdchk(7'(n * 8), 32'(1 | (n * 4) << 8 | (n < 4 ? (n < 2 ? 5 : 7 - n) : 0) << 16));
			rdchk(7'(n * 8 + 4), 32'(n));
		end
		chk(32'(steps), {20'h0, 3'h4, 3'h5, 3'h5, 3'h5});
		// three periods of the slowest channel, so the short first slot is gone
		repeat (31000) @(posedge clock_i);
		for (int n = 0; n < NCH; n++) begin
			chk(32'(hi[n]), 32'((n * 4 + 1) * (n + 1) * TB_CYCLES));
			chk(32'(per[n]), 32'(32 * (n + 1) * TB_CYCLES));
		end
		for (int n = 0; n < NCH; n++) begin
			xfer(1'b1, 7'(n * 8), 32'h0, 4'hF);
		end
		repeat (4) @(posedge clock_i);
		chk(32'(gates), 32'h0);
		rdchk(OFS_STATUS, 32'h0);
		report_and_stop();
	end
endmodule
